// ===== hw/scd_client_decoder.sv
// client command decoder: parses target, lengths, command and write
// data from a byte stream and returns fcs, data and fcs bytes
// assumes the link layer flags the first byte of each frame, reports the
// bus stop, and keeps fcs_i current over all bytes of the frame so far
`timescale 1ns/1ps
module scd_client_decoder
  import scd_pkg::*;
(
  input  wire logic        sys_clk_i,        // 40 mhz clock
  input  wire logic        arst_n_i,         // async reset, low active
  input  wire logic        clk_en_i,         // freezes state when low
  input  wire logic        strap_gnd_i,      // strap pin sensed at ground
  input  wire logic        strap_vdd_i,      // strap pin sensed at supply
  input  wire logic        rx_valid_i,       // received byte strobe
  input  wire logic        rx_first_i,       // byte is first of frame
  input  wire logic [7:0]  rx_data_i,        // received byte
  input  wire logic        bus_stop_i,       // stop seen on the bus
  input  wire logic [7:0]  fcs_i,            // good fcs of frame so far
  input  wire logic        tx_ready_i,       // link takes a byte
  output logic             tx_valid_o,       // byte offered
  output logic [7:0]       tx_data_o,        // byte to send
  output logic             tx_last_o,        // offered byte ends answer
  input  wire logic [15:0] temp_int_i,       // internal temperature
  input  wire logic [15:0] temp_ext_i,       // remote temperature
  input  wire logic [15:0] rail_twelve_i,    // 12 v reading
  input  wire logic [15:0] rail_five_i,      // 5 v reading
  input  wire logic [15:0] rail_three_i,     // 3.3 v reading
  input  wire logic [15:0] rail_two_five_i,  // 2.5 v reading
  input  wire logic [15:0] rail_core_i,      // core rail reading
  output logic [7:0]       vreg_addr_o,      // vendor register address
  output logic [7:0]       vreg_wdata_o,     // vendor register data
  output logic             vreg_we_o,        // vendor write pulse
  input  wire logic [7:0]  vreg_rdata_i,     // data at vreg_addr_o
  output logic             vendor_en_o,      // vendor access enabled
  output logic             client_reset_o,   // client reset pulse
  output logic [7:0]       dev_addr_o        // strapped bus address
);

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  scd_state_t state_reg;
  logic [7:0] wr_len_reg;
  logic [7:0] rd_len_reg;
  logic [7:0] cmd_reg;
  logic [7:0] wr_left_reg;
  logic [7:0] idx_reg;
  logic       abort_reg;
  logic       stop_after_reg;
  logic       first_wbyte_reg;
  logic       strap_taken_reg;

  // abort and wait-for-stop decision for a command and its lengths
  function automatic logic [1:0] judge(input logic [7:0] cmd,
                                       input logic [7:0] wr,
                                       input logic [7:0] rd,
                                       input logic       ven);
    logic bad_wr;
    logic bad_rd;
    bad_wr = (wr != LEN_ONE);
    bad_rd = 1'b0;
    judge  = 2'b00;
    if (cmd == CMD_TEMP_INT || cmd == CMD_TEMP_EXT ||
        (cmd >= CMD_RAIL_FIRST && cmd <= CMD_RAIL_LAST))
    begin
      if (cmd == CMD_TEMP_INT)
        bad_rd = !(rd == LEN_TWO || rd == LEN_FOUR);
      else if (cmd == CMD_RAIL_FIRST)
        bad_rd = !(rd == LEN_TWO || rd == LEN_TEN);
      else
        bad_rd = (rd != LEN_TWO);
      if (bad_wr)
        judge = 2'b10;
      else if (bad_rd)
        judge = 2'b11;
    end
    else if (cmd == CMD_VREG_WR || cmd == CMD_VREG_RD)
      judge = {!ven, 1'b0};
    else if (cmd == CMD_VEN_ON || cmd == CMD_VEN_OFF ||
             cmd == CMD_CLIENT_RST)
      judge = {bad_wr || rd != IDENT_ZERO, 1'b0};
    else if (cmd == CMD_IDENT_RD)
    begin
      if (bad_wr)
        judge = 2'b10;
      else if (!(rd == LEN_IDENT_HALF || rd == LEN_IDENT_FULL))
        judge = 2'b11;
    end
    else
      judge = 2'b10;
  endfunction

  // identifier block byte; unlisted positions read zero
  function automatic logic [7:0] ident_byte(input logic [7:0] i,
                                            input logic [7:0] addr);
    if (i == IDX_DEV_IF)
      ident_byte = IDENT_DEV_IF;
    else if (i == IDX_MAKER_LO)
      ident_byte = IDENT_MAKER[7:0];
    else if (i == IDX_MAKER_HI)
      ident_byte = IDENT_MAKER[15:8];
    else if (i == IDX_PART_LO)
      ident_byte = IDENT_PART[7:0];
    else if (i == IDX_PART_HI)
      ident_byte = IDENT_PART[15:8];
    else if (i == IDX_ADDR)
      ident_byte = addr;
    else
      ident_byte = IDENT_ZERO;
  endfunction

  // answer data byte at position idx_reg; one address serves both sets
  logic [15:0] word_sel;
  logic [7:0]  data_byte;
  always_comb
  begin
    word_sel = temp_int_i;
    if (cmd_reg == CMD_TEMP_INT)
      word_sel = idx_reg[1] ? temp_ext_i : temp_int_i;
    else if (cmd_reg == CMD_TEMP_EXT)
      word_sel = temp_ext_i;
    else if (cmd_reg == CMD_RAIL_FIRST)
    begin
      if (idx_reg[7:1] == 7'h01)
        word_sel = rail_five_i;
      else if (idx_reg[7:1] == 7'h02)
        word_sel = rail_three_i;
      else if (idx_reg[7:1] == 7'h03)
        word_sel = rail_two_five_i;
      else if (idx_reg[7:1] == 7'h04)
        word_sel = rail_core_i;
      else
        word_sel = rail_twelve_i;
    end
    else if (cmd_reg == CMD_RAIL_FIVE)
      word_sel = rail_five_i;
    else if (cmd_reg == CMD_RAIL_THREE)
      word_sel = rail_three_i;
    else if (cmd_reg == CMD_RAIL_TWO5)
      word_sel = rail_two_five_i;
    else if (cmd_reg == CMD_RAIL_LAST)
      word_sel = rail_core_i;
    if (cmd_reg == CMD_IDENT_RD)
      data_byte = ident_byte(idx_reg, dev_addr_o);
    else if (cmd_reg == CMD_VREG_RD)
      data_byte = vreg_rdata_i;
    else
      data_byte = idx_reg[0] ? word_sel[15:8] : word_sel[7:0];
  end

  // strap caught once after reset release, never under reset itself
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_addr_o      <= ADDR_FLOAT;
      strap_taken_reg <= 1'b0;
    end
    else if (clk_en_i && !strap_taken_reg)
    begin
      strap_taken_reg <= 1'b1;
      if (strap_gnd_i)
        dev_addr_o <= ADDR_GND;
      else if (strap_vdd_i)
        dev_addr_o <= ADDR_VDD;
      else
        dev_addr_o <= ADDR_FLOAT;
    end
  end

  wire tx_take = tx_valid_o && tx_ready_i;
  wire [1:0] verdict = judge(cmd_reg, wr_len_reg, rd_len_reg,
                             vendor_en_o);

  // frame parser and answer sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg       <= ST_IDLE;
      wr_len_reg      <= 8'h00;
      rd_len_reg      <= 8'h00;
      cmd_reg         <= 8'h00;
      wr_left_reg     <= 8'h00;
      idx_reg         <= 8'h00;
      abort_reg       <= 1'b0;
      stop_after_reg  <= 1'b0;
      first_wbyte_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      // a new frame start resyncs any state except the stop wait
      if (rx_valid_i && rx_first_i && state_reg != ST_STOP)
      begin
        state_reg <= (rx_data_i == dev_addr_o) ? ST_WRLEN : ST_STOP;
        abort_reg      <= 1'b0;
        stop_after_reg <= 1'b0;  // a cut ping must not leak forward
      end
      else
      begin
        case (state_reg)
          ST_WRLEN:
            if (rx_valid_i)
            begin
              wr_len_reg <= rx_data_i;
              state_reg  <= ST_RDLEN;
            end
          ST_RDLEN:
            if (rx_valid_i)
            begin
              rd_len_reg <= rx_data_i;
              if (wr_len_reg == 8'h00)
              begin
                // ping: a lone good fcs, or abort if data is asked
                abort_reg      <= (rx_data_i != 8'h00);
                stop_after_reg <= (rx_data_i != 8'h00);
                state_reg      <= ST_FCS1;
              end
              else
                state_reg <= ST_CMD;
            end
          ST_CMD:
            if (rx_valid_i)
            begin
              cmd_reg         <= rx_data_i;
              wr_left_reg     <= wr_len_reg - 8'h01;
              first_wbyte_reg <= 1'b1;
              state_reg       <= (wr_len_reg == LEN_ONE) ? ST_FCS1
                                                         : ST_WDATA;
            end
          ST_WDATA:
            if (rx_valid_i)
            begin
              first_wbyte_reg <= 1'b0;
              wr_left_reg     <= wr_left_reg - 8'h01;
              if (wr_left_reg == 8'h01)
                state_reg <= ST_FCS1;
            end
          ST_FCS1:
            if (tx_take)
            begin
              idx_reg <= 8'h00;
              if (abort_reg || verdict[1])
                state_reg <= (stop_after_reg || verdict[0]) ? ST_STOP
                                                            : ST_IDLE;
              else if (wr_len_reg != 8'h00 && rd_len_reg != 8'h00)
                state_reg <= ST_DATA;
              else
                state_reg <= ST_IDLE;
            end
          ST_DATA:
            if (tx_take)
            begin
              idx_reg <= idx_reg + 8'h01;
              if (idx_reg == rd_len_reg - 8'h01)
                state_reg <= ST_FCS2;
            end
          ST_FCS2:
            if (tx_take)
              state_reg <= ST_IDLE;
          ST_STOP:
            if (bus_stop_i)
              state_reg <= ST_IDLE;
          default:
            state_reg <= ST_IDLE;
        endcase
        if (tx_take && state_reg == ST_FCS1)
          stop_after_reg <= 1'b0;
      end
    end
  end

  // answer bytes held in flops; one idle cycle between bytes
  wire sending = (state_reg == ST_FCS1) || (state_reg == ST_DATA) ||
                 (state_reg == ST_FCS2);
  wire fcs_abort = abort_reg || (wr_len_reg != 8'h00 && verdict[1]);
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_last_o  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (tx_take || (rx_valid_i && rx_first_i))
        tx_valid_o <= 1'b0;
      else if (sending && !tx_valid_o)
      begin
        tx_valid_o <= 1'b1;
        if (state_reg == ST_DATA)
        begin
          tx_data_o <= data_byte;
          tx_last_o <= 1'b0;
        end
        else if (state_reg == ST_FCS1)
        begin
          tx_data_o <= fcs_i ^ {8{fcs_abort}};
          tx_last_o <= fcs_abort || wr_len_reg == 8'h00 ||
                       rd_len_reg == 8'h00;
        end
        else
        begin
          tx_data_o <= fcs_i;
          tx_last_o <= 1'b1;
        end
      end
    end
  end

  // vendor register port and control commands
  wire cmd_ok_take = tx_take && state_reg == ST_FCS1 && !fcs_abort;
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vreg_addr_o    <= 8'h00;
      vreg_wdata_o   <= 8'h00;
      vreg_we_o      <= 1'b0;
      vendor_en_o    <= 1'b0;
      client_reset_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      vreg_we_o      <= 1'b0;
      client_reset_o <= 1'b0;
      if (state_reg == ST_WDATA && rx_valid_i && !rx_first_i &&
          vendor_en_o &&
          (cmd_reg == CMD_VREG_WR || cmd_reg == CMD_VREG_RD))
      begin
        if (first_wbyte_reg)
          vreg_addr_o <= rx_data_i;
        else if (cmd_reg == CMD_VREG_WR)
        begin
          vreg_wdata_o <= rx_data_i;
          vreg_we_o    <= 1'b1;
        end
      end
      // step the address after each write pulse and each read byte
      if (vreg_we_o || (tx_take && state_reg == ST_DATA &&
                        cmd_reg == CMD_VREG_RD))
        vreg_addr_o <= vreg_addr_o + 8'h01;
      if (cmd_ok_take && cmd_reg == CMD_VEN_ON)
        vendor_en_o <= 1'b1;
      else if (cmd_ok_take && (cmd_reg == CMD_VEN_OFF ||
                               cmd_reg == CMD_CLIENT_RST))
        vendor_en_o <= 1'b0;                 // test codes stay shut
      if (cmd_ok_take && cmd_reg == CMD_CLIENT_RST)
        client_reset_o <= 1'b1;
    end
  end

endmodule // scd_client_decoder

// ===== hw/scd_pkg.sv
// constants, codes and states for the client command decoder
// assumes a link layer outside that frames bytes and computes the fcs
package scd_pkg;

  // command codes
  localparam logic [7:0] CMD_TEMP_INT   = 8'h00;
  localparam logic [7:0] CMD_TEMP_EXT   = 8'h01;
  localparam logic [7:0] CMD_RAIL_FIRST = 8'h10;
  localparam logic [7:0] CMD_RAIL_FIVE  = 8'h11;
  localparam logic [7:0] CMD_RAIL_THREE = 8'h12;
  localparam logic [7:0] CMD_RAIL_TWO5  = 8'h13;
  localparam logic [7:0] CMD_RAIL_LAST  = 8'h14;
  localparam logic [7:0] CMD_VREG_WR    = 8'he0;
  localparam logic [7:0] CMD_VREG_RD    = 8'he1;
  localparam logic [7:0] CMD_VEN_ON     = 8'he2;
  localparam logic [7:0] CMD_VEN_OFF    = 8'he3;
  localparam logic [7:0] CMD_CLIENT_RST = 8'hf6;
  localparam logic [7:0] CMD_IDENT_RD   = 8'hf7;

  // lengths
  localparam logic [7:0] LEN_ONE        = 8'h01;
  localparam logic [7:0] LEN_TWO        = 8'h02;
  localparam logic [7:0] LEN_FOUR       = 8'h04;
  localparam logic [7:0] LEN_TEN        = 8'h0a;
  localparam logic [7:0] LEN_IDENT_HALF = 8'h08;
  localparam logic [7:0] LEN_IDENT_FULL = 8'h10;

  // bus addresses by strap state
  localparam logic [7:0] ADDR_GND   = 8'h48;
  localparam logic [7:0] ADDR_FLOAT = 8'h49;
  localparam logic [7:0] ADDR_VDD   = 8'h4a;

  // identifier block contents; maker and part codes are arbitrary
  localparam logic [15:0] IDENT_MAKER   = 16'h5a3c;
  localparam logic [15:0] IDENT_PART    = 16'h0a17;
  localparam logic [7:0]  IDENT_DEV_IF  = 8'h02;
  localparam logic [7:0]  IDENT_ZERO    = 8'h00;

  // identifier block byte positions
  localparam logic [7:0] IDX_DEV_IF    = 8'h00;
  localparam logic [7:0] IDX_FUNC_IF   = 8'h01;
  localparam logic [7:0] IDX_IF_EXT    = 8'h02;
  localparam logic [7:0] IDX_MAKER_LO  = 8'h03;
  localparam logic [7:0] IDX_MAKER_HI  = 8'h04;
  localparam logic [7:0] IDX_PART_LO   = 8'h05;
  localparam logic [7:0] IDX_PART_HI   = 8'h06;
  localparam logic [7:0] IDX_ADDR      = 8'h07;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,  // waiting for target byte
    ST_WRLEN = 4'b0001,
    ST_RDLEN = 4'b0010,
    ST_CMD   = 4'b0011,
    ST_WDATA = 4'b0100,  // remaining write bytes
    ST_FCS1  = 4'b0101,
    ST_DATA  = 4'b0110,
    ST_FCS2  = 4'b0111,
    ST_STOP  = 4'b1000   // ignore everything until bus stop
  } scd_state_t;

endpackage

// ===== verification/scd_dec_asserts.sv
// port checker for the client command decoder
// assumes it is bound to scd_client_decoder, single clock
`timescale 1ns/1ps
module scd_dec_asserts (
  input wire logic       sys_clk_i,      // clock
  input wire logic       arst_n_i,       // reset
  input wire logic       strap_gnd_i,    // strap low
  input wire logic       strap_vdd_i,    // strap high
  input wire logic       rx_valid_i,     // rx strobe
  input wire logic       rx_first_i,     // frame start
  input wire logic [7:0] fcs_i,          // good fcs
  input wire logic       tx_ready_i,     // tx accept
  input wire logic       tx_valid_o,     // tx offer
  input wire logic [7:0] tx_data_o,      // tx byte
  input wire logic       tx_last_o,      // tx end
  input wire logic [7:0] vreg_addr_o,    // reg address
  input wire logic       vreg_we_o,      // reg write
  input wire logic       vendor_en_o,    // vendor on
  input wire logic       client_reset_o, // reset pulse
  input wire logic [7:0] dev_addr_o      // bus address
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [2:0] up_reg;  // edges since release, saturates
  // strap is only judged once the reset synchroniser has let go
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      up_reg <= 3'h0;
    else if (up_reg != 3'h7)
      up_reg <= up_reg + 3'h1;
  end

  property p_addr;
    up_reg == 3'h7 |-> dev_addr_o ==
      (strap_gnd_i ? 8'h48 : (strap_vdd_i ? 8'h4a : 8'h49));
  endproperty
  a_addr: assert property (p_addr)
    else $error("bus address does not follow strap");

  property p_hold;
    tx_valid_o && !tx_ready_i && !(rx_valid_i && rx_first_i) |=>
      tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offered byte changed before it was taken");

  property p_next;
    tx_valid_o && tx_ready_i && !tx_last_o |=> !tx_valid_o ##1 tx_valid_o;
  endproperty
  a_next: assert property (p_next)
    else $error("answer did not continue after one idle cycle");

  property p_last;
    tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o [*2];
  endproperty
  a_last: assert property (p_last)
    else $error("byte offered after end of answer");

  property p_fcs;
    tx_valid_o && tx_last_o |-> (tx_data_o == fcs_i) ||
      (tx_data_o == ~fcs_i);
  endproperty
  a_fcs: assert property (p_fcs)
    else $error("closing byte is neither fcs nor its inverse");

  property p_we;
    vreg_we_o |=> !vreg_we_o &&
      vreg_addr_o == $past(vreg_addr_o) + 8'h01;
  endproperty
  a_we: assert property (p_we)
    else $error("register write not a pulse or address not stepped");

  property p_gate;
    vreg_we_o |-> vendor_en_o;
  endproperty
  a_gate: assert property (p_gate)
    else $error("register written with vendor access off");

  property p_rst;
    client_reset_o |=> !client_reset_o ##1 !vendor_en_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("client reset left vendor access on");

  // main traffic seen at least once
  c_end: cover property (tx_valid_o && tx_ready_i && tx_last_o);
  c_we: cover property (vreg_we_o);
  c_rst: cover property (client_reset_o);
endmodule  // scd_dec_asserts

bind scd_client_decoder scd_dec_asserts u_chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .strap_gnd_i(strap_gnd_i), .strap_vdd_i(strap_vdd_i),
  .rx_valid_i(rx_valid_i), .rx_first_i(rx_first_i), .fcs_i(fcs_i),
  .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
  .vreg_addr_o(vreg_addr_o), .vreg_we_o(vreg_we_o),
  .vendor_en_o(vendor_en_o), .client_reset_o(client_reset_o),
  .dev_addr_o(dev_addr_o)
);

// ===== verification/scd_link_model.sv
// link model: accepts offered bytes and keeps a frame check
// assumes one clock shared with the decoder
`timescale 1ns/1ps
module scd_link_model (
  input  wire logic       clk_i,      // clock
  input  wire logic       rst_n_i,    // reset, low active
  input  wire logic       slow_i,     // stall each offer
  input  wire logic       rx_valid_i, // byte to client
  input  wire logic       rx_first_i, // first of frame
  input  wire logic [7:0] rx_data_i,  // byte value
  input  wire logic       tx_valid_i, // client offers
  input  wire logic [7:0] tx_data_i,  // offered byte
  output logic            tx_ready_o, // byte accepted
  output logic [7:0]      fcs_o       // check so far
);
  logic [1:0] wait_reg;  // stall counter
  // stand-in check: rotate and xor, restarted by each target byte
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fcs_o <= 8'h00;
    else if (rx_valid_i && rx_first_i)
      fcs_o <= rx_data_i;
    else if (rx_valid_i)
      fcs_o <= {fcs_o[6:0], fcs_o[7]} ^ rx_data_i;
    else if (tx_valid_i && tx_ready_o)
      fcs_o <= {fcs_o[6:0], fcs_o[7]} ^ tx_data_i;
  end
  // ready is never given two edges running, so no byte is taken twice
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_ready_o <= 1'b0;
      wait_reg <= 2'h0;
    end
    else
    begin
      tx_ready_o <= tx_valid_i && !tx_ready_o &&
                    (!slow_i || wait_reg == 2'h3);
      wait_reg <= (tx_valid_i && !tx_ready_o) ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule  // scd_link_model

// ===== verification/tb_top.sv
// testbench for the client command decoder
// assumes the checker and the link model are compiled first
`timescale 1ns/1ps
module tb_top;
  import scd_pkg::*;
  logic        clk = 1'b0, arst_n, s_gnd, s_vdd, rx_v, rx_f, stop, slow;
  logic        tx_rdy, tx_v, tx_l, v_we, ven, c_rst, cen;
  logic [7:0]  rx_d, fcs, tx_d, v_addr, v_wd, v_rd, dev_addr;
  logic [15:0] t_int, t_ext;
  logic [15:0] rail [0:4];
  logic [7:0]  vmem [0:255];
  logic [7:0]  idb [0:15];
  int          n_mismatch = 0;
  int          check_count = 0;

  always #12.5 clk = ~clk;
  // register file behind the vendor port, read combinationally
  always @(posedge clk)
    if (v_we)
      vmem[v_addr] <= v_wd;
  assign v_rd = vmem[v_addr];

  scd_client_decoder uut (.sys_clk_i(clk), .arst_n_i(arst_n),
    .clk_en_i(cen), .strap_gnd_i(s_gnd), .strap_vdd_i(s_vdd),
    .rx_valid_i(rx_v), .rx_first_i(rx_f), .rx_data_i(rx_d),
    .bus_stop_i(stop), .fcs_i(fcs), .tx_ready_i(tx_rdy),
    .tx_valid_o(tx_v), .tx_data_o(tx_d), .tx_last_o(tx_l),
    .temp_int_i(t_int), .temp_ext_i(t_ext), .rail_twelve_i(rail[0]),
    .rail_five_i(rail[1]), .rail_three_i(rail[2]),
    .rail_two_five_i(rail[3]), .rail_core_i(rail[4]),
    .vreg_addr_o(v_addr), .vreg_wdata_o(v_wd), .vreg_we_o(v_we),
    .vreg_rdata_i(v_rd), .vendor_en_o(ven), .client_reset_o(c_rst),
    .dev_addr_o(dev_addr));
  scd_link_model u_link (.clk_i(clk), .rst_n_i(arst_n), .slow_i(slow),
    .rx_valid_i(rx_v), .rx_first_i(rx_f), .rx_data_i(rx_d),
    .tx_valid_i(tx_v), .tx_data_i(tx_d), .tx_ready_o(tx_rdy),
    .fcs_o(fcs));

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task do_reset(input logic g, input logic v);
    arst_n <= 1'b0;
    s_gnd <= g;
    s_vdd <= v;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task send(input logic f, input logic [7:0] d);
    @(posedge clk);
    rx_v <= 1'b1;
    rx_f <= f;
    rx_d <= d;
    @(posedge clk);
    rx_v <= 1'b0;
    rx_f <= 1'b0;
  endtask
  task stop_p;
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
  endtask
  task frame(input logic [7:0] a, w, r, c);
    send(1'b1, a);
    send(1'b0, w);
    send(1'b0, r);
    if (w != 8'h00)
      send(1'b0, c);
  endtask
  // kind 0 data, 1 good check, 2 inverted check; judged at the take
  task recv(input int k, input logic [7:0] d, input logic l);
    int i;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (tx_v === 1'b1 && tx_rdy === 1'b1)
        break;
    end
    if (i == 200)
      n_mismatch++;
    if (k == 1)
      d = fcs;
    if (k == 2)
      d = ~fcs;
    chk(tx_d, d);
    chk({7'h00, tx_l}, {7'h00, l});
  endtask
  task word(input logic [15:0] w);
    recv(0, w[7:0], 1'b0);
    recv(0, w[15:8], 1'b0);
  endtask
  task ask(input logic [7:0] c, r);
    frame(ADDR_GND, LEN_ONE, r, c);
    recv(1, 8'h00, 1'b0);
  endtask
  task fin;
    recv(1, 8'h00, 1'b1);
  endtask
  task ping;
    frame(ADDR_GND, 8'h00, 8'h00, 8'h00);
  endtask
  task silent(input int n);
    repeat (n)
    begin
      @(posedge clk);
      chk({7'h00, tx_v}, 8'h00);
    end
  endtask

  task t_temp;
    ask(CMD_TEMP_INT, LEN_TWO);  // opening
    word(t_int);  // internal reading
    fin;  // closing
    slow <= 1'b1;
    ask(CMD_TEMP_EXT, LEN_TWO);  // stalled link
    word(t_ext);  // remote reading
    fin;  // closing
    slow <= 1'b0;
    ask(CMD_TEMP_INT, LEN_FOUR);  // both readings
    word(t_int);  // internal first
    word(t_ext);  // remote second
    fin;  // closing
  endtask
  task t_rail;
    int i;
    for (i = 0; i < 5; i++)
    begin
      ask(CMD_RAIL_FIRST + i[7:0], LEN_TWO);  // own address
      word(rail[i]);  // one rail
      fin;  // closing
    end
    ask(CMD_RAIL_FIRST, LEN_TEN);  // all rails
    for (i = 0; i < 5; i++)
      word(rail[i]);  // rail order
    fin;  // closing
  endtask
  task t_ident;
    int i;
    for (i = 0; i < 16; i++)
      idb[i] = 8'h00;  // zero fields
    idb[0] = IDENT_DEV_IF;  // interface byte
    idb[3] = IDENT_MAKER[7:0];  // maker low first
    idb[4] = IDENT_MAKER[15:8];  // maker high
    idb[5] = IDENT_PART[7:0];  // part low first
    idb[6] = IDENT_PART[15:8];  // part high
    idb[7] = ADDR_GND;  // strapped address
    ask(CMD_IDENT_RD, LEN_IDENT_FULL);  // full block
    for (i = 0; i < 16; i++)
      recv(0, idb[i], 1'b0);  // block bytes
    fin;  // closing
    ask(CMD_IDENT_RD, LEN_IDENT_HALF);  // half block
    for (i = 0; i < 8; i++)
      recv(0, idb[i], 1'b0);  // block bytes
    fin;  // closing
  endtask
  task t_abort;
    logic [7:0] bad [0:10] = '{8'h02, 8'h0f, 8'h15, 8'hdf, 8'he4,
      8'he7, 8'he8, 8'hef, 8'hf5, 8'hf8, 8'hff};
    int i;
    for (i = 0; i < 11; i++)
    begin
      frame(ADDR_GND, LEN_ONE, LEN_TWO, bad[i]);
      recv(2, 8'h00, 1'b1);  // inverted
      ping;
      fin;  // still answers
    end
  endtask
  task t_length;
    frame(ADDR_GND, 8'h02, LEN_TWO, CMD_TEMP_INT);
    fork
      send(1'b0, 8'h55);
      recv(2, 8'h00, 1'b1);  // bad write length
    join
    ping;
    fin;  // back to idle at once
    frame(ADDR_GND, LEN_ONE, 8'h03, CMD_RAIL_FIRST);
    recv(2, 8'h00, 1'b1);  // bad read length
    ping;
    silent(20);  // waits for stop
    cen <= 1'b0;
    stop_p;
    cen <= 1'b1;
    ping;
    silent(20);  // stop ignored while frozen
    stop_p;
    frame(8'h4b, 8'h00, 8'h00, 8'h00);
    silent(20);  // other address ignored
    stop_p;
    ping;
    fin;  // answers after stop
  endtask
  task t_vendor;
    frame(ADDR_GND, 8'h04, 8'h00, CMD_VREG_WR);
    fork
      begin
        send(1'b0, 8'h30);
        send(1'b0, 8'h77);
        send(1'b0, 8'h78);
      end
      recv(2, 8'h00, 1'b1);  // refused while off
    join
    chk(vmem[8'h30], 8'h00);  // nothing written
    frame(ADDR_GND, LEN_ONE, 8'h00, CMD_VEN_ON);
    fin;  // enable answer
    @(posedge clk);
    chk({7'h00, ven}, 8'h01);  // access on
    frame(ADDR_GND, 8'h04, 8'h00, CMD_VREG_WR);
    send(1'b0, 8'h20);
    send(1'b0, 8'h25);
    send(1'b0, 8'h28);
    fin;  // write answer
    chk(vmem[8'h20], 8'h25);  // first location
    chk(vmem[8'h21], 8'h28);  // next location
    frame(ADDR_GND, 8'h02, 8'h02, CMD_VREG_RD);
    send(1'b0, 8'h20);
    recv(1, 8'h00, 1'b0);  // opening
    recv(0, 8'h25, 1'b0);  // read back
    recv(0, 8'h28, 1'b0);  // read back
    fin;  // closing
    frame(ADDR_GND, LEN_ONE, 8'h00, CMD_VEN_OFF);
    fin;  // disable answer
    @(posedge clk);
    chk({7'h00, ven}, 8'h00);  // access off
    frame(ADDR_GND, LEN_ONE, 8'h00, CMD_VEN_ON);
    fin;  // enable answer
    frame(ADDR_GND, LEN_ONE, 8'h00, CMD_CLIENT_RST);
    fin;  // reset answer
    @(posedge clk);
    chk({7'h00, c_rst}, 8'h01);  // reset pulse
    @(posedge clk);
    chk({7'h00, c_rst}, 8'h00);  // one cycle only
    @(posedge clk);
    chk({7'h00, ven}, 8'h00);  // reset drops access
  endtask
  task t_strap;
    do_reset(1'b0, 1'b0);
    chk(dev_addr, ADDR_FLOAT);  // floating strap
    do_reset(1'b0, 1'b1);
    chk(dev_addr, ADDR_VDD);  // strap at supply
    frame(ADDR_VDD, 8'h00, 8'h00, 8'h00);
    fin;  // ping at new address
    do_reset(1'b1, 1'b0);
    chk(dev_addr, ADDR_GND);  // strap at ground
  endtask

  // main sequence
  initial
  begin
    rx_v = 1'b0;
    rx_f = 1'b0;
    rx_d = 8'h00;
    stop = 1'b0;
    slow = 1'b0;
    cen = 1'b1;
    t_int = 16'h3c01;
    t_ext = 16'h2a02;
    rail = '{16'h3003, 16'h1404, 16'h0d05, 16'h0a06, 16'h0707};
    vmem[8'h30] = 8'h00;
    do_reset(1'b1, 1'b0);
    t_temp;
    t_rail;
    t_ident;
    t_abort;
    t_length;
    t_vendor;
    t_strap;
    wrap_up;
  end
  // hang guard, well beyond the several hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule  // tb_top
